// *** psw_map.svh ***
// register offsets, field positions and reset values of the status register bank
`ifndef PSW_MAP_SVH
`define PSW_MAP_SVH

`define PSW_ADDR_W 8
`define PSW_DATA_W 16

`define PSW_OFS_CLEAR_FAULTS 8'h03
`define PSW_OFS_VOUT_SETTING 8'h21
`define PSW_OFS_VOUT_LIMIT 8'h24
`define PSW_OFS_STATUS_BYTE 8'h78
`define PSW_OFS_STATUS_WORD 8'h79
`define PSW_OFS_VOUT_STATUS 8'h7A
`define PSW_OFS_IRQ_STATUS 8'hE0
`define PSW_OFS_IRQ_ENABLE 8'hE1
`define PSW_OFS_IRQ_CLEAR 8'hE2

`define PSW_WORD_VOUT 15
`define PSW_WORD_IOUT 14
`define PSW_WORD_INPUT 13
`define PSW_WORD_VENDOR 12
`define PSW_WORD_PWR_OK_N 11

`define PSW_BYTE_OFF 6
`define PSW_BYTE_VOUT_OV 5
`define PSW_BYTE_IOUT_OC 4
`define PSW_BYTE_INPUT_UV 3
`define PSW_BYTE_TEMP 2
`define PSW_BYTE_CML 1
`define PSW_BYTE_OTHER 0

`define PSW_VST_OV 7
`define PSW_VST_UV 4
`define PSW_VST_MAX 3

`define PSW_RST_VOUT_STATUS 8'h00
`define PSW_RST_STATUS_WORD 16'h0000
`define PSW_RST_VOUT_SETTING 16'h0000
`define PSW_RST_VOUT_LIMIT 16'hFFFF
`define PSW_RST_IRQ_ENABLE 8'h00

`endif

// *** psw_pkg.sv ***
// types shared by the status register bank modules
package psw_pkg;
	// positions of the latched fault flags inside the flag bank
	typedef enum logic [3:0] {
		PSW_F_OUT_OV = 4'h0,
		PSW_F_OUT_UV = 4'h1,
		PSW_F_OUT_MAX = 4'h2,
		PSW_F_IOUT_OCF = 4'h3,
		PSW_F_IOUT_OCW = 4'h4,
		PSW_F_VIN_OVF = 4'h5,
		PSW_F_VIN_UVF = 4'h6,
		PSW_F_IIN_OCF = 4'h7,
		PSW_F_IIN_OCW = 4'h8,
		PSW_F_TEMP_OTF = 4'h9,
		PSW_F_TEMP_OTW = 4'hA,
		PSW_F_CML = 4'hB,
		PSW_F_VENDOR = 4'hC
	} psw_flag_type;
	localparam int PSW_NUM_FLAGS = 13;
	localparam int PSW_NUM_IRQ = 8;
	typedef logic [PSW_NUM_FLAGS-1:0] psw_flag_vec_type;
	typedef logic [PSW_NUM_IRQ-1:0] psw_irq_vec_type;
endpackage

// *** psw_flag_if.sv ***
// set, clear and state of a bank of sticky flags
`timescale 1ns/1ps
`default_nettype none
interface psw_flag_if #(
	parameter int N = 13
);
	logic [N-1:0] set;
	logic [N-1:0] clr;
	logic [N-1:0] flags;
	modport bank (input set, input clr, output flags);
	modport user (output set, output clr, input flags);
endinterface
`default_nettype wire

// *** psw_flag_bank.sv ***
// bank of sticky flags, set wins over clear
`timescale 1ns/1ps
`default_nettype none
module psw_flag_bank #(
	parameter int N = 13
) (
	input wire logic core_clk,
	input wire logic rst_n,
	psw_flag_if.bank fl
);
	logic [N-1:0] flag_reg;

	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_flag
			always_ff @(posedge core_clk or negedge rst_n) begin
				if (!rst_n) begin
					flag_reg[i] <= 1'b0;
				end else if (fl.set[i]) begin
					flag_reg[i] <= 1'b1;
				end else if (fl.clr[i]) begin
					flag_reg[i] <= 1'b0;
				end
			end
		end
	endgenerate

	assign fl.flags = flag_reg;
endmodule
`default_nettype wire

// *** psw_irq_ctrl.sv ***
// sticky interrupt status, enable and write-one-to-clear, one level output
`timescale 1ns/1ps
`default_nettype none
module psw_irq_ctrl #(
	parameter int N = 8
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [N-1:0] evt,
	input wire logic clr_wr,
	input wire logic [N-1:0] clr_data,
	input wire logic en_wr,
	input wire logic [N-1:0] en_data,
	output logic [N-1:0] status,
	output logic [N-1:0] enable,
	output logic irq
);
	logic [N-1:0] status_reg;
	logic [N-1:0] enable_reg;
	logic irq_reg;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			status_reg <= '0;
		end else begin
			// an event in the clearing cycle survives
			status_reg <= (status_reg & ~(clr_wr ? clr_data : '0)) | evt;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			enable_reg <= '0;
		end else if (en_wr) begin
			enable_reg <= en_data;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= |(status_reg & enable_reg);
		end
	end

	assign status = status_reg;
	assign enable = enable_reg;
	assign irq = irq_reg;
endmodule
`default_nettype wire

// *** psw_status_top.sv ***
// status word and output-voltage status registers of the buck controller
// Functional notes
// - word bit 15 latches when any output-voltage fault or warning has occurred.
// - word bit 14 latches when any output-current fault or warning has occurred.
// - word bit 13 latches when any input-voltage or input-current fault or warning occurred.
// - word bit 12 latches when a vendor-defined fault has occurred.
// - word bit 11 is a live copy of the inverted regulator ready pin.
// - word bits 10..8 and voltage status bits 6, 5, 2, 1, 0 always read zero.
// - the output-voltage status byte sits at command code 7Ah and resets to zero.
// - voltage status bit 7 latches once an output overvoltage fault has occurred.
// - voltage status bit 4 latches once an output undervoltage fault has occurred.
// - voltage status bit 3 latches when a setting above the permitted maximum is tried.
// - the word's low byte is the same storage as the single status byte.
// - every reported fault or warning except input undervoltage drives the alert line.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "psw_map.svh"
module psw_status_top
	import psw_pkg::*;
#(
	parameter int ADDR_W = `PSW_ADDR_W,
	parameter int DATA_W = `PSW_DATA_W
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DATA_W-1:0] reg_rdata,
	input wire logic out_overvoltage_fault,
	input wire logic out_undervoltage_fault,
	input wire logic iout_overcurrent_fault,
	input wire logic iout_overcurrent_warning,
	input wire logic vin_overvoltage_fault,
	input wire logic input_undervoltage,
	input wire logic iin_overcurrent_fault,
	input wire logic iin_overcurrent_warning,
	input wire logic temp_over_fault,
	input wire logic temp_over_warning,
	input wire logic cml_fault,
	input wire logic vendor_defined_fault,
	input wire logic regulator_ready_pin,
	input wire logic output_off,
	output logic [DATA_W-1:0] vout_setting,
	output logic host_alert_line_n,
	output logic irq
);
	psw_flag_if #(.N(PSW_NUM_FLAGS)) flag_bus ();

	logic wr_clear_faults;
	logic wr_vout_setting;
	logic wr_vout_limit;
	logic wr_irq_enable;
	logic wr_irq_clear;
	logic over_limit;
	psw_flag_vec_type flag_set;
	psw_flag_vec_type flag_now;
	psw_flag_vec_type flag_prev_reg;
	psw_flag_vec_type flag_rise;
	psw_irq_vec_type irq_evt;
	psw_irq_vec_type irq_status;
	psw_irq_vec_type irq_enable;
	logic irq_line;
	logic power_ok_inverted;
	logic power_ok_prev_reg;
	logic power_ok_primed_reg;
	logic vout_summary;
	logic iout_summary;
	logic input_summary;
	logic vendor_fault_summary;
	logic temp_summary;
	logic other_summary;
	logic [7:0] status_byte;
	logic [15:0] summary_status_word;
	logic [7:0] output_voltage_status;
	logic [DATA_W-1:0] vout_setting_reg;
	logic [DATA_W-1:0] vout_limit_reg;
	logic [DATA_W-1:0] rdata_reg;
	logic [DATA_W-1:0] rdata_next;
	logic alert_n_reg;
	logic alert_n_next;

	// write decode; the bus never stalls, every write lands in its own cycle
	assign wr_clear_faults = reg_wr && (reg_addr == `PSW_OFS_CLEAR_FAULTS);
	assign wr_vout_setting = reg_wr && (reg_addr == `PSW_OFS_VOUT_SETTING);
	assign wr_vout_limit = reg_wr && (reg_addr == `PSW_OFS_VOUT_LIMIT);
	assign wr_irq_enable = reg_wr && (reg_addr == `PSW_OFS_IRQ_ENABLE);
	assign wr_irq_clear = reg_wr && (reg_addr == `PSW_OFS_IRQ_CLEAR);

	assign over_limit = wr_vout_setting && (reg_wdata > vout_limit_reg);

	// a refused setting leaves the old value in place rather than clamping
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			vout_setting_reg <= `PSW_RST_VOUT_SETTING;
		end else if (wr_vout_setting && !over_limit) begin
			vout_setting_reg <= reg_wdata;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			vout_limit_reg <= `PSW_RST_VOUT_LIMIT;
		end else if (wr_vout_limit) begin
			vout_limit_reg <= reg_wdata;
		end
	end

	// conditions are levels: a flag whose cause still stands stays set through a clear, since set wins
	always_comb begin
		flag_set = '0;
		flag_set[PSW_F_OUT_OV] = out_overvoltage_fault;
		flag_set[PSW_F_OUT_UV] = out_undervoltage_fault;
		flag_set[PSW_F_OUT_MAX] = over_limit;
		flag_set[PSW_F_IOUT_OCF] = iout_overcurrent_fault;
		flag_set[PSW_F_IOUT_OCW] = iout_overcurrent_warning;
		flag_set[PSW_F_VIN_OVF] = vin_overvoltage_fault;
		flag_set[PSW_F_VIN_UVF] = input_undervoltage;
		flag_set[PSW_F_IIN_OCF] = iin_overcurrent_fault;
		flag_set[PSW_F_IIN_OCW] = iin_overcurrent_warning;
		flag_set[PSW_F_TEMP_OTF] = temp_over_fault;
		flag_set[PSW_F_TEMP_OTW] = temp_over_warning;
		flag_set[PSW_F_CML] = cml_fault;
		flag_set[PSW_F_VENDOR] = vendor_defined_fault;
	end

	assign flag_bus.set = flag_set;
	assign flag_bus.clr = {PSW_NUM_FLAGS{wr_clear_faults}};
	assign flag_now = flag_bus.flags;

	psw_flag_bank #(.N(PSW_NUM_FLAGS)) u_flags (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.fl(flag_bus)
	);

	assign vout_summary = flag_now[PSW_F_OUT_OV] | flag_now[PSW_F_OUT_UV]
		| flag_now[PSW_F_OUT_MAX];
	assign iout_summary = flag_now[PSW_F_IOUT_OCF] | flag_now[PSW_F_IOUT_OCW];
	assign input_summary = flag_now[PSW_F_VIN_OVF] | flag_now[PSW_F_VIN_UVF]
		| flag_now[PSW_F_IIN_OCF] | flag_now[PSW_F_IIN_OCW];
	assign vendor_fault_summary = flag_now[PSW_F_VENDOR];
	assign temp_summary = flag_now[PSW_F_TEMP_OTF] | flag_now[PSW_F_TEMP_OTW];
	// faults with no bit of their own in the low byte, except the vendor fault, fall into the catch-all
	assign other_summary = flag_now[PSW_F_OUT_UV] | flag_now[PSW_F_OUT_MAX]
		| flag_now[PSW_F_IOUT_OCW] | flag_now[PSW_F_VIN_OVF]
		| flag_now[PSW_F_IIN_OCF] | flag_now[PSW_F_IIN_OCW];
	assign power_ok_inverted = ~regulator_ready_pin;

	always_comb begin
		status_byte = 8'h00;
		status_byte[`PSW_BYTE_OFF] = output_off;
		status_byte[`PSW_BYTE_VOUT_OV] = flag_now[PSW_F_OUT_OV];
		status_byte[`PSW_BYTE_IOUT_OC] = flag_now[PSW_F_IOUT_OCF];
		status_byte[`PSW_BYTE_INPUT_UV] = flag_now[PSW_F_VIN_UVF];
		status_byte[`PSW_BYTE_TEMP] = temp_summary;
		status_byte[`PSW_BYTE_CML] = flag_now[PSW_F_CML];
		status_byte[`PSW_BYTE_OTHER] = other_summary;
	end

	always_comb begin
		summary_status_word = `PSW_RST_STATUS_WORD;
		summary_status_word[`PSW_WORD_VOUT] = vout_summary;
		summary_status_word[`PSW_WORD_IOUT] = iout_summary;
		summary_status_word[`PSW_WORD_INPUT] = input_summary;
		summary_status_word[`PSW_WORD_VENDOR] = vendor_fault_summary;
		summary_status_word[`PSW_WORD_PWR_OK_N] = power_ok_inverted;
		summary_status_word[7:0] = status_byte;
	end

	always_comb begin
		// bits 6, 5, 2..0 stay zero
		output_voltage_status = `PSW_RST_VOUT_STATUS;
		output_voltage_status[`PSW_VST_OV] = flag_now[PSW_F_OUT_OV];
		output_voltage_status[`PSW_VST_UV] = flag_now[PSW_F_OUT_UV];
		output_voltage_status[`PSW_VST_MAX] = flag_now[PSW_F_OUT_MAX];
	end

	// register read mux; unmapped and write-only offsets answer zero
	always_comb begin
		rdata_next = '0;
		unique case (reg_addr)
			`PSW_OFS_STATUS_BYTE: begin
				rdata_next = {{(DATA_W-8){1'b0}}, status_byte};
			end
			`PSW_OFS_STATUS_WORD: begin
				rdata_next = summary_status_word;
			end
			`PSW_OFS_VOUT_STATUS: begin
				rdata_next = {{(DATA_W-8){1'b0}}, output_voltage_status};
			end
			`PSW_OFS_VOUT_SETTING: begin
				rdata_next = vout_setting_reg;
			end
			`PSW_OFS_VOUT_LIMIT: begin
				rdata_next = vout_limit_reg;
			end
			`PSW_OFS_IRQ_STATUS: begin
				rdata_next = {{(DATA_W-PSW_NUM_IRQ){1'b0}}, irq_status};
			end
			`PSW_OFS_IRQ_ENABLE: begin
				rdata_next = {{(DATA_W-PSW_NUM_IRQ){1'b0}}, irq_enable};
			end
			// write-only strobes read back as zero so software cannot mistake them for state
			`PSW_OFS_CLEAR_FAULTS, `PSW_OFS_IRQ_CLEAR: begin
				rdata_next = '0;
			end
			default: begin
				rdata_next = '0;
			end
		endcase
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg <= '0;
		end else if (reg_rd) begin
			rdata_reg <= rdata_next;
		end else begin
			rdata_reg <= '0;
		end
	end

	always_comb begin
		alert_n_next = 1'b1;
		if (|(flag_now & ~(PSW_NUM_FLAGS'(1) << PSW_F_VIN_UVF))) begin
			alert_n_next = 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			alert_n_reg <= 1'b1;
		end else begin
			alert_n_reg <= alert_n_next;
		end
	end

	// interrupt events 0..6 fire once per newly latched flag, not while it stays set
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			flag_prev_reg <= '0;
		end else begin
			flag_prev_reg <= flag_now;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			power_ok_prev_reg <= 1'b0;
		end else begin
			power_ok_prev_reg <= power_ok_inverted;
		end
	end

	// the pin may sit low through reset; the first cycle only primes the history
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			power_ok_primed_reg <= 1'b0;
		end else begin
			power_ok_primed_reg <= 1'b1;
		end
	end

	assign flag_rise = flag_now & ~flag_prev_reg;

	always_comb begin
		irq_evt = '0;
		irq_evt[0] = flag_rise[PSW_F_OUT_OV] | flag_rise[PSW_F_OUT_UV];
		irq_evt[1] = flag_rise[PSW_F_OUT_MAX];
		irq_evt[2] = flag_rise[PSW_F_IOUT_OCF] | flag_rise[PSW_F_IOUT_OCW];
		irq_evt[3] = flag_rise[PSW_F_VIN_OVF] | flag_rise[PSW_F_VIN_UVF]
			| flag_rise[PSW_F_IIN_OCF] | flag_rise[PSW_F_IIN_OCW];
		irq_evt[4] = flag_rise[PSW_F_TEMP_OTF] | flag_rise[PSW_F_TEMP_OTW];
		irq_evt[5] = flag_rise[PSW_F_CML];
		irq_evt[6] = flag_rise[PSW_F_VENDOR];
		irq_evt[7] = power_ok_primed_reg & (power_ok_inverted ^ power_ok_prev_reg);
	end

	psw_irq_ctrl #(.N(PSW_NUM_IRQ)) u_irq (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.evt(irq_evt),
		.clr_wr(wr_irq_clear),
		.clr_data(reg_wdata[PSW_NUM_IRQ-1:0]),
		.en_wr(wr_irq_enable),
		.en_data(reg_wdata[PSW_NUM_IRQ-1:0]),
		.status(irq_status),
		.enable(irq_enable),
		.irq(irq_line)
	);

	assign reg_rdata = rdata_reg;
	assign vout_setting = vout_setting_reg;
	assign host_alert_line_n = alert_n_reg;
	assign irq = irq_line;
endmodule
`default_nettype wire

// *** psw_status_checker.sv ***
// concurrent checks on the ports of the status register bank
`timescale 1ns/1ps
`default_nettype none
module psw_status_checker (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic out_overvoltage_fault,
	input wire logic out_undervoltage_fault,
	input wire logic iout_overcurrent_fault,
	input wire logic iout_overcurrent_warning,
	input wire logic vin_overvoltage_fault,
	input wire logic input_undervoltage,
	input wire logic iin_overcurrent_fault,
	input wire logic iin_overcurrent_warning,
	input wire logic vendor_defined_fault,
	input wire logic regulator_ready_pin,
	input wire logic host_alert_line_n
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	logic rd_w;
	logic rd_v;
	logic clr;
	logic in_any;
	assign rd_w = reg_rd && reg_addr == 8'h79;
	assign rd_v = reg_rd && reg_addr == 8'h7A;
	assign clr = reg_wr && reg_addr == 8'h03;
	assign in_any = vin_overvoltage_fault || input_undervoltage || iin_overcurrent_fault
		|| iin_overcurrent_warning;
	AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 16'h0000)
		else $error("read data not zero outside a read answer");
	AST_VOUT_TIED: assert property (rd_v |=> reg_rdata[15:8] == 8'h00
		&& reg_rdata[6:5] == 2'b00 && reg_rdata[2:0] == 3'b000)
		else $error("unsupported voltage status bits not zero");
	AST_WORD_TIED: assert property (rd_w |=> reg_rdata[10:8] == 3'b000)
		else $error("unsupported word bits not zero");
	AST_PWR_OK: assert property (rd_w |=> reg_rdata[11] == !$past(regulator_ready_pin))
		else $error("word bit 11 not the inverted ready pin");
	AST_OVF: assert property (out_overvoltage_fault ##1 rd_v |=> reg_rdata[7])
		else $error("overvoltage flag not latched");
	AST_UVF: assert property (out_undervoltage_fault ##1 rd_v |=> reg_rdata[4])
		else $error("undervoltage flag not latched");
	AST_WORD_VOUT: assert property ((out_overvoltage_fault || out_undervoltage_fault)
		##1 rd_w |=> reg_rdata[15])
		else $error("word voltage summary not set");
	AST_WORD_IOUT: assert property ((iout_overcurrent_fault || iout_overcurrent_warning)
		##1 rd_w |=> reg_rdata[14])
		else $error("word current summary not set");
	AST_WORD_INPUT: assert property (in_any ##1 rd_w |=> reg_rdata[13])
		else $error("word input summary not set");
	AST_WORD_VENDOR: assert property (vendor_defined_fault ##1 rd_w |=> reg_rdata[12])
		else $error("word vendor summary not set");
	AST_ALERT: assert property (vendor_defined_fault |=> ##1 !host_alert_line_n)
		else $error("alert not driven after a fault");
	AST_STICKY: assert property (!host_alert_line_n && !clr && !$past(clr) |=>
		!host_alert_line_n)
		else $error("alert released without a clear");
	cover property (rd_w ##1 reg_rdata[15]);
	cover property (clr);
	cover property (!host_alert_line_n ##1 host_alert_line_n);
endmodule
bind psw_status_top psw_status_checker chk_u (.core_clk(core_clk), .rst_n(rst_n),
	.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.out_overvoltage_fault(out_overvoltage_fault),
	.out_undervoltage_fault(out_undervoltage_fault),
	.iout_overcurrent_fault(iout_overcurrent_fault),
	.iout_overcurrent_warning(iout_overcurrent_warning),
	.vin_overvoltage_fault(vin_overvoltage_fault), .input_undervoltage(input_undervoltage),
	.iin_overcurrent_fault(iin_overcurrent_fault),
	.iin_overcurrent_warning(iin_overcurrent_warning),
	.vendor_defined_fault(vendor_defined_fault), .regulator_ready_pin(regulator_ready_pin),
	.host_alert_line_n(host_alert_line_n));
`default_nettype wire

// *** psw_host_model.sv ***
// host side of the register port, one strobe per read or write call, none per idle call
`timescale 1ns/1ps
`default_nettype none
module psw_host_model (
	input wire logic core_clk,
	input wire logic [15:0] reg_rdata,
	output logic [7:0] reg_addr,
	output logic [15:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// strobe left high so a following call sets it once per step
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		reg_rd <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic idle();
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		@(posedge core_clk);
	endtask
	// answer stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		reg_addr <= a;
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
		@(posedge core_clk);
	endtask
endmodule
`default_nettype wire

// *** pmbus_status_word_vout_flags_bench.sv ***
// self-checking bench for the status word and output-voltage status registers
`timescale 1ns/1ps
`default_nettype none
module pmbus_status_word_vout_flags_bench;
	logic core_clk, rst_n, reg_wr, reg_rd, ready, off, irq, alert_n, maxw;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, vout_setting, d, b;
	logic [11:0] flt, st;
	logic [31:0] r1, r2;
	integer bad_count, comparisons, cycles, i, seed;
	psw_host_model host_u (.core_clk(core_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
	psw_status_top dut_u (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.out_overvoltage_fault(flt[0]), .out_undervoltage_fault(flt[1]),
		.iout_overcurrent_fault(flt[2]), .iout_overcurrent_warning(flt[3]),
		.vin_overvoltage_fault(flt[4]), .input_undervoltage(flt[5]),
		.iin_overcurrent_fault(flt[6]), .iin_overcurrent_warning(flt[7]),
		.temp_over_fault(flt[8]), .temp_over_warning(flt[9]), .cml_fault(flt[10]),
		.vendor_defined_fault(flt[11]), .regulator_ready_pin(ready), .output_off(off),
		.vout_setting(vout_setting), .host_alert_line_n(alert_n), .irq(irq));
	always #2.5 core_clk = ~core_clk;
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// fault levels high for one cycle; model flags latch at that edge
	task automatic pulse(input logic [11:0] f, input logic r, input logic o);
		flt <= f;
		ready <= r;
		off <= o;
		@(posedge core_clk);
		flt <= 12'h000;
		st = st | f;
	endtask
	task automatic settle();
		repeat (3) @(posedge core_clk);
		#1;
	endtask
	task automatic check_all();
		host_u.rd(8'h79, d);
		chk("word_high", {8'h00, d[15:8]}, {8'h00, st[0] | st[1] | maxw, st[2] | st[3],
			|st[7:4], st[11], ~ready, 3'b000});
		host_u.rd(8'h78, b);
		chk("byte_vs_word", b, {8'h00, d[7:0]});
		chk("status_byte", b, {8'h00, 1'b0, off, st[0], st[2], st[5], st[8] | st[9], st[10],
			st[1] | maxw | st[3] | st[4] | st[6] | st[7]});
		host_u.rd(8'h7A, d);
		chk("vout_status", d, {8'h00, st[0], 2'b00, st[1], maxw, 3'b000});
		chk("alert", {15'h0000, alert_n}, {15'h0000, ~(|(st & 12'hFDF) | maxw)});
	endtask
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			conclude();
		end
	end
	initial begin
		core_clk = 1'b0;
		rst_n = 1'b0;
		flt = 12'h000;
		ready = 1'b1;
		off = 1'b0;
		st = 12'h000;
		maxw = 1'b0;
		bad_count = 0;
		comparisons = 0;
		cycles = 0;
		seed = 32'ha30917f6;
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		check_all();
		host_u.rd(8'h55, d);
		chk("unmapped", d, 16'h0000);
		// input undervoltage alone must leave the alert high
		pulse(12'h020, 1'b1, 1'b0);
		check_all();
		for (i = 0; i < 40; i++) begin
			r1 = $random(seed);
			r2 = $random(seed);
			pulse(r1[11:0] & r2[11:0] & r2[23:12], r1[31], r1[30]);
			check_all();
			if (i % 8 == 7) begin
				host_u.wr(8'h03, r2[31:16]);
				st = 12'h000;
				maxw = 1'b0;
				check_all();
			end
		end
		// voltage status read straight after the fault cycle
		pulse(12'h003, ready, off);
		host_u.rd(8'h7A, d);
		chk("vout_direct", d, {8'h00, st[0], 2'b00, st[1], maxw, 3'b000});
		host_u.wr(8'h03, 16'h0000);
		st = 12'h000;
		// setting equal to the limit is accepted, one above is refused
		host_u.wr(8'h24, 16'h0100);
		host_u.wr(8'h21, 16'h0100);
		host_u.idle();
		check_all();
		chk("setting", vout_setting, 16'h0100);
		host_u.wr(8'h21, 16'h0101);
		host_u.idle();
		maxw = 1'b1;
		check_all();
		chk("setting_kept", vout_setting, 16'h0100);
		// vendor event: masked, then enabled, then cleared
		host_u.wr(8'hE1, 16'h0000);
		host_u.wr(8'hE2, 16'h00FF);
		host_u.idle();
		pulse(12'h800, ready, off);
		settle();
		chk("irq_masked", {15'h0000, irq}, 16'h0000);
		host_u.rd(8'hE0, d);
		chk("irq_status", d, 16'h0040);
		host_u.wr(8'hE1, 16'h0040);
		host_u.idle();
		settle();
		chk("irq_on", {15'h0000, irq}, 16'h0001);
		host_u.wr(8'hE2, 16'h0040);
		host_u.idle();
		settle();
		chk("irq_off", {15'h0000, irq}, 16'h0000);
		// reset in mid-run drops every latched flag
		rst_n <= 1'b0;
		@(posedge core_clk);
		rst_n <= 1'b1;
		st = 12'h000;
		maxw = 1'b0;
		@(posedge core_clk);
		check_all();
		conclude();
	end
endmodule
`default_nettype wire
